// [core/subcarrier_ctrl.sv]
// Subcarrier reset and real-time control input handling
`timescale 1ns/1ps
module subcarrier_ctrl (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              arst_n,
  // Configuration and events
  input  wire venc_pkg::sc_cfg_t cfg,
  input  wire logic              field_start,
  input  wire logic              subcarrier_ctrl_pin,
  // Status
  output logic [1:0]             field_seq,
  output logic                   rtc_lock,
  output logic [7:0]             rtc_word
);
  typedef struct packed {
    logic       pin_d;
    logic [1:0] seq;
    logic [7:0] word;
    logic [2:0] bits;
    logic       lock;
  } sc_state_t;

  sc_state_t st;
  sc_state_t next_st;

  always_comb begin
    next_st = st;
    next_st.pin_d = subcarrier_ctrl_pin;
    if (field_start) begin
      next_st.seq = st.seq + 2'h1;
    end
    case (cfg)
      venc_pkg::SC_RESET: begin
        if (!st.pin_d && subcarrier_ctrl_pin) begin
          next_st.seq = 2'h0;
        end
        next_st.lock = 1'b0;
      end
      venc_pkg::SC_RTC: begin
        next_st.word = {st.word[6:0], subcarrier_ctrl_pin};
        next_st.bits = st.bits + 3'h1;
        if (st.bits == 3'h7) begin
          next_st.lock = 1'b1;
        end
      end
      default: begin
        next_st.lock = 1'b0;
        next_st.bits = 3'h0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '{pin_d: 1'b0, seq: 2'h0, word: 8'h00, bits: 3'h0, lock: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign field_seq = st.seq;
  assign rtc_lock  = st.lock;
  assign rtc_word  = st.word;
endmodule

// [core/sync_timing_gen.sv]
// Video timing generator with master and slave sync pins
`timescale 1ns/1ps
module sync_timing_gen (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  arst_n,
  // Configuration
  input  wire logic                  master,
  input  wire venc_pkg::timing_mode_t tmode,
  // Sync pins
  input  wire logic                  hsync_in,
  input  wire logic                  field_vsync_in,
  output logic                       hsync_out,
  output logic                       hsync_oe_n,
  output logic                       field_vsync_out,
  output logic                       field_vsync_oe_n,
  // Timing status
  output logic                       line_start,
  output logic                       field_start,
  output logic                       vbi,
  output logic                       field
);
  typedef struct packed {
    logic [11:0] h_cnt;
    logic [9:0]  v_cnt;
    logic        field;
    logic        hs_out;
    logic        fv_out;
    logic        hs_oe_n;
    logic        fv_oe_n;
    logic        hs_d;
    logic        fv_d;
    logic        line_start;
    logic        field_start;
    logic        vbi;
  } tg_state_t;

  tg_state_t st;
  tg_state_t next_st;
  logic      drive;
  logic      line_end;
  logic      field_end;

  always_comb begin
    next_st = st;
    next_st.line_start  = 1'b0;
    next_st.field_start = 1'b0;
    next_st.hs_d = hsync_in;
    next_st.fv_d = field_vsync_in;
    drive = master && (tmode == venc_pkg::TMODE_1 || tmode == venc_pkg::TMODE_2);
    line_end  = (st.h_cnt == venc_pkg::LINE_CLOCKS - 12'h001);
    field_end = line_end && (st.v_cnt == venc_pkg::FIELD_LINES - 10'h001);
    // Free-running counters
    next_st.h_cnt = line_end ? 12'h000 : st.h_cnt + 12'h001;
    if (line_end) begin
      next_st.line_start = 1'b1;
      next_st.v_cnt = field_end ? 10'h000 : st.v_cnt + 10'h001;
    end
    if (field_end) begin
      next_st.field = ~st.field;
      next_st.field_start = 1'b1;
    end
    // Slave: realign on incoming sync edges
    if (!master) begin
      if (st.hs_d && !hsync_in) begin
        next_st.h_cnt = 12'h000;
        next_st.line_start = 1'b1;
      end
      if (tmode == venc_pkg::TMODE_2 && st.fv_d && !field_vsync_in) begin
        next_st.v_cnt = 10'h000;
        next_st.field = ~st.field;
        next_st.field_start = 1'b1;
      end else if (tmode == venc_pkg::TMODE_1 && st.fv_d != field_vsync_in) begin
        next_st.v_cnt = 10'h000;
        next_st.field = field_vsync_in;
        next_st.field_start = 1'b1;
      end
    end
    // Master in modes 1 and 2: drive pins, oe low while driving
    next_st.hs_oe_n = ~drive;
    next_st.fv_oe_n = ~drive;
    next_st.hs_out = ~(next_st.h_cnt < venc_pkg::HSYNC_CLOCKS);
    if (tmode == venc_pkg::TMODE_1) begin
      next_st.fv_out = next_st.field;
    end else begin
      next_st.fv_out = ~(next_st.v_cnt < venc_pkg::VSYNC_LINES);
    end
    next_st.vbi = next_st.v_cnt < venc_pkg::VBI_LINES;
  end

  // Reset reinitialises the generator
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '{h_cnt: 12'h000, v_cnt: 10'h000, field: 1'b0, hs_out: 1'b1, fv_out: 1'b1,
              hs_oe_n: 1'b1, fv_oe_n: 1'b1, hs_d: 1'b1, fv_d: 1'b1, line_start: 1'b0,
              field_start: 1'b0, vbi: 1'b1};
    end else begin
      st <= next_st;
    end
  end

  assign hsync_out        = st.hs_out;
  assign hsync_oe_n       = st.hs_oe_n;
  assign field_vsync_out  = st.fv_out;
  assign field_vsync_oe_n = st.fv_oe_n;
  assign line_start       = st.line_start;
  assign field_start      = st.field_start;
  assign vbi              = st.vbi;
  assign field            = st.field;
endmodule

// [core/venc_pkg.sv]
// Shared constants for the video encoder pin port
package venc_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_MODE   = 8'h00;
  localparam logic [7:0] OFS_MODE2  = 8'h04;
  localparam logic [7:0] OFS_DAC    = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_PIXEL  = 8'h10;

  // Mode register fields
  localparam int MODE_PAL_BIT    = 0;
  localparam int MODE_MASTER_BIT = 1;
  localparam int MODE_TMODE_LSB  = 2;
  localparam int MODE_PIX16_BIT  = 4;

  // Second mode register fields
  localparam int MODE2_SC_LO_BIT = 1;
  localparam int MODE2_SC_HI_BIT = 2;
  localparam int MODE2_TTX_BIT   = 3;

  // Values after reset
  localparam logic [7:0] MODE_RESET  = 8'h00;
  localparam logic [7:0] MODE2_RESET = 8'h00;
  localparam logic [3:0] DAC_RESET   = 4'h7;

  // Serial control-port address, upper six bits, value is arbitrary
  localparam logic [5:0] SERIAL_ADDR_BASE = 6'h2A;

  // Timing generator counts, plain defaults
  localparam logic [11:0] LINE_CLOCKS   = 12'h400;
  localparam logic [9:0]  FIELD_LINES   = 10'h106;
  localparam logic [11:0] HSYNC_CLOCKS  = 12'h040;
  localparam logic [9:0]  VSYNC_LINES   = 10'h003;
  localparam logic [9:0]  VBI_LINES     = 10'h014;

  typedef enum logic [1:0] {TMODE_0, TMODE_1, TMODE_2, TMODE_3} timing_mode_t;
  typedef enum logic [1:0] {SC_OFF, SC_RESET, SC_RTC, SC_OFF2} sc_cfg_t;
endpackage

// [core/video_encoder_pin_port.sv]
// Top of the video encoder pin port with Avalon-MM register slave
//
// Implementation choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
// Overview of operation
// - Pixel port takes 8-bit or 16-bit YCrCb.
// - Horizontal sync driven as master in timing modes 1 and 2, received as slave.
// - Field or vsync pin by timing mode.
// - Pixel inputs ignored while blanking is low.
// - Address select pin sets address LSB.
// - Reset restores NTSC, slave mode 0, 8-bit.
// - Reset powers converters one to three on, four off.
// - Two mode bits choose subcarrier pin function.
// - Rising edge resets subcarrier sequence to zero.
// - In the RTC setting pin is real-time subcarrier lock input; the two off settings leave it unused.
// - Teletext request held low when not selected.
// - Teletext data reads high when not selected.
module video_encoder_pin_port (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // Avalon-MM register slave
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  // Pixel port
  input  wire logic [15:0] pixel_bus,
  input  wire logic        blank_n,
  output logic [15:0]      pixel_word,
  output logic             pixel_valid,
  // Sync pins
  input  wire logic        hsync_in,
  output logic             hsync_out,
  output logic             hsync_oe_n,
  input  wire logic        field_vsync_in,
  output logic             field_vsync_out,
  output logic             field_vsync_oe_n,
  // Serial control-port address
  input  wire logic        addr_select_pin,
  output logic [6:0]       serial_slave_addr,
  // Subcarrier control pin
  input  wire logic        subcarrier_ctrl_pin,
  // Teletext port
  output logic             teletext_request_out,
  input  wire logic        teletext_data_in,
  output logic             teletext_bit,
  // Output converter power enables
  output logic [3:0]       dac_power
);
  typedef struct packed {
    logic [7:0]  mode;
    logic [7:0]  mode2;
    logic [3:0]  dac;
    logic [31:0] rdata;
    logic        wait_n;
    logic [15:0] pix;
    logic        pix_valid;
    logic [6:0]  saddr;
    logic        ttx_req;
    logic        ttx_bit;
  } top_state_t;

  top_state_t st;
  top_state_t next_st;

  logic                   master;
  venc_pkg::timing_mode_t tmode;
  venc_pkg::sc_cfg_t      sc_cfg;
  logic                   ttx_en;
  logic                   line_start;
  logic                   field_start;
  logic                   vbi;
  logic                   field;
  logic [1:0]             field_seq;
  logic                   rtc_lock;
  logic [7:0]             rtc_word;
  logic [31:0]            rd_mux;
  logic                   access;

  assign master = st.mode[venc_pkg::MODE_MASTER_BIT];
  assign tmode  = venc_pkg::timing_mode_t'(st.mode[venc_pkg::MODE_TMODE_LSB +: 2]);
  assign sc_cfg = venc_pkg::sc_cfg_t'({st.mode2[venc_pkg::MODE2_SC_HI_BIT],
                                       st.mode2[venc_pkg::MODE2_SC_LO_BIT]});
  assign ttx_en = st.mode2[venc_pkg::MODE2_TTX_BIT];

  sync_timing_gen u_timing (
    .clk              (clk),
    .arst_n           (arst_n),
    .master           (master),
    .tmode            (tmode),
    .hsync_in         (hsync_in),
    .field_vsync_in   (field_vsync_in),
    .hsync_out        (hsync_out),
    .hsync_oe_n       (hsync_oe_n),
    .field_vsync_out  (field_vsync_out),
    .field_vsync_oe_n (field_vsync_oe_n),
    .line_start       (line_start),
    .field_start      (field_start),
    .vbi              (vbi),
    .field            (field)
  );

  subcarrier_ctrl u_subcarrier (
    .clk                 (clk),
    .arst_n              (arst_n),
    .cfg                 (sc_cfg),
    .field_start         (field_start),
    .subcarrier_ctrl_pin (subcarrier_ctrl_pin),
    .field_seq           (field_seq),
    .rtc_lock            (rtc_lock),
    .rtc_word            (rtc_word)
  );

  // Read data selection
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (address == venc_pkg::OFS_MODE) begin
      rd_mux = {24'h00_0000, st.mode};
    end else if (address == venc_pkg::OFS_MODE2) begin
      rd_mux = {24'h00_0000, st.mode2};
    end else if (address == venc_pkg::OFS_DAC) begin
      rd_mux = {28'h000_0000, st.dac};
    end else if (address == venc_pkg::OFS_STATUS) begin
      rd_mux = {8'h00, rtc_word, 1'b0, st.saddr, st.ttx_bit, vbi, field, rtc_lock,
                2'h0, field_seq};
    end else if (address == venc_pkg::OFS_PIXEL) begin
      rd_mux = {15'h0000, st.pix_valid, st.pix};
    end
  end

  always_comb begin
    next_st = st;
    access = read || write;
    // Bus: one wait cycle, then the answer for one cycle
    next_st.wait_n = access && !st.wait_n;
    if (access && !st.wait_n) begin
      next_st.rdata = rd_mux;
    end
    if (write && st.wait_n && byteenable[0]) begin
      if (address == venc_pkg::OFS_MODE) begin
        next_st.mode = writedata[7:0];
      end else if (address == venc_pkg::OFS_MODE2) begin
        next_st.mode2 = writedata[7:0];
      end else if (address == venc_pkg::OFS_DAC) begin
        next_st.dac = writedata[3:0];
      end
    end
    // Pixel capture, sampled on the rising edge
    next_st.pix_valid = blank_n;
    if (blank_n) begin
      if (st.mode[venc_pkg::MODE_PIX16_BIT]) begin
        next_st.pix = pixel_bus;
      end else begin
        next_st.pix = {8'h00, pixel_bus[7:0]};
      end
    end
    // Serial address follows the select pin
    next_st.saddr = {venc_pkg::SERIAL_ADDR_BASE, addr_select_pin};
    // Teletext request once per blanking line
    next_st.ttx_req = ttx_en && vbi && line_start;
    next_st.ttx_bit = ttx_en ? teletext_data_in : 1'b1;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '{mode: venc_pkg::MODE_RESET, mode2: venc_pkg::MODE2_RESET,
              dac: venc_pkg::DAC_RESET, rdata: 32'h0000_0000, wait_n: 1'b0,
              pix: 16'h0000, pix_valid: 1'b0, saddr: 7'h00, ttx_req: 1'b0,
              ttx_bit: 1'b1};
    end else begin
      st <= next_st;
    end
  end

  assign readdata             = st.rdata;
  assign waitrequest          = ~st.wait_n;
  assign pixel_word           = st.pix;
  assign pixel_valid          = st.pix_valid;
  assign serial_slave_addr    = st.saddr;
  assign teletext_request_out = st.ttx_req;
  assign teletext_bit         = st.ttx_bit;
  assign dac_power            = st.dac;
endmodule

// [sim/video_encoder_pin_port_assertions.sv]
// Assertions on the video encoder pin port
`timescale 1ns/1ps
module video_encoder_pin_port_assertions (
  // Clock and reset
  input wire logic        clk,
  input wire logic        arst_n,
  // Register bus
  input wire logic [7:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [3:0]  byteenable,
  input wire logic        waitrequest,
  // Pixel port
  input wire logic [15:0] pixel_bus,
  input wire logic        blank_n,
  input wire logic [15:0] pixel_word,
  input wire logic        pixel_valid,
  // Pins
  input wire logic        hsync_out,
  input wire logic        hsync_oe_n,
  input wire logic        field_vsync_oe_n,
  input wire logic        addr_select_pin,
  input wire logic [6:0]  serial_slave_addr,
  input wire logic        teletext_request_out,
  input wire logic        teletext_bit,
  input wire logic [3:0]  dac_power
);
  logic [4:0] mode;
  logic       ttx_en;
  logic [7:0] lo_cnt;
  logic       wr_ok;
  logic       drv;
  assign wr_ok = write && !waitrequest && byteenable[0];
  assign drv = mode[1] && (mode[3:2] == 2'h1 || mode[3:2] == 2'h2);
  // Mirror of mode bits, low time of hsync
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode <= 5'h00;
      ttx_en <= 1'b0;
      lo_cnt <= 8'h00;
    end else begin
      if (wr_ok && address == venc_pkg::OFS_MODE) mode <= writedata[4:0];
      if (wr_ok && address == venc_pkg::OFS_MODE2) ttx_en <= writedata[3];
      lo_cnt <= (hsync_out || hsync_oe_n) ? 8'h00 : lo_cnt + 8'h01;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence req_s; (read || write) && waitrequest; endsequence
  sequence ans_s; !waitrequest ##1 waitrequest; endsequence
  bus_answer_a: assert property (req_s |=> ans_s)
    else $error("bus answer wrong");
  pix_capture_a: assert property (
    blank_n |=> pixel_valid && pixel_word[7:0] == $past(pixel_bus[7:0]))
    else $error("pixel not captured");
  pix_ignore_a: assert property (!blank_n |=> !pixel_valid && $stable(pixel_word))
    else $error("pixel taken while blanked");
  wide_word_a: assert property (
    blank_n |=> pixel_word[15:8] == ($past(mode[4]) ? $past(pixel_bus[15:8]) : 8'h00))
    else $error("upper pixel byte wrong");
  addr_lsb_a: assert property (
    $past(arst_n) |-> serial_slave_addr == {venc_pkg::SERIAL_ADDR_BASE, $past(addr_select_pin)})
    else $error("serial address wrong");
  sync_dir_a: assert property (
    drv == $past(drv) |-> hsync_oe_n == !drv && field_vsync_oe_n == !drv)
    else $error("sync pin direction wrong");
  hs_width_a: assert property (lo_cnt <= 8'h40)
    else $error("hsync low too long");
  ttx_idle_a: assert property (
    !ttx_en && !$past(ttx_en) |-> !teletext_request_out && teletext_bit)
    else $error("teletext active while off");
  reset_state_a: assert property ($rose(arst_n) |->
    dac_power == venc_pkg::DAC_RESET && hsync_oe_n && field_vsync_oe_n && !pixel_valid)
    else $error("reset state wrong");
endmodule
bind video_encoder_pin_port video_encoder_pin_port_assertions i_chk (.clk, .arst_n,
  .address, .read, .write, .writedata, .byteenable, .waitrequest, .pixel_bus, .blank_n,
  .pixel_word, .pixel_valid, .hsync_out, .hsync_oe_n, .field_vsync_oe_n, .addr_select_pin,
  .serial_slave_addr, .teletext_request_out, .teletext_bit, .dac_power);

// [sim/video_encoder_pin_port_test.sv]
// Self-checking bench for the video encoder pin port
`timescale 1ns/1ps
module video_encoder_pin_port_test;
  logic        clk = 1'b0, arst_n = 1'b0, read = 1'b0, write = 1'b0, run = 1'b0;
  logic [7:0]  address = 8'h00;
  logic [31:0] writedata = 32'h0, readdata;
  logic [3:0]  byteenable = 4'h0, dac_power;
  logic [15:0] pixel_bus, pixel_word;
  logic        waitrequest, blank_n, pixel_valid, hsync_in, hsync_out, hsync_oe_n;
  logic        field_vsync_in, field_vsync_out, field_vsync_oe_n, teletext_request_out;
  logic        addr_select_pin = 1'b0, subcarrier_ctrl_pin = 1'b0;
  logic        teletext_data_in = 1'b0, teletext_bit;
  logic [6:0]  serial_slave_addr;
  int          n_fail = 0;
  int          n_compared = 0;
  always #12.5 clk = ~clk;
  video_source i_src (.clk, .run, .pixel_bus, .blank_n, .hsync_in, .field_vsync_in);
  video_encoder_pin_port i_dut (.clk, .arst_n, .address, .read, .write, .writedata,
    .byteenable, .readdata, .waitrequest, .pixel_bus, .blank_n, .pixel_word, .pixel_valid,
    .hsync_in, .hsync_out, .hsync_oe_n, .field_vsync_in, .field_vsync_out,
    .field_vsync_oe_n, .addr_select_pin, .serial_slave_addr, .subcarrier_ctrl_pin,
    .teletext_request_out, .teletext_data_in, .teletext_bit, .dac_power);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask
  task automatic conclude();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic expire();
    n_fail++;
    $display("[FAIL] %0t wait limit", $time);
    conclude();
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    int k;
    k = 0;
    address <= a;
    writedata <= d;
    byteenable <= be;
    read <= !w;
    write <= w;
    do begin
      @(posedge clk);
      k++;
      if (k > 20) expire();
    end while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'hF, q);
  endtask
  task automatic wait_hs(input logic v);
    int k;
    k = 0;
    while (hsync_out !== v) begin
      @(posedge clk);
      k++;
      if (k > 1100) expire();
    end
  endtask
  task automatic t_regs();
    logic [31:0] q;
    chk(32'(dac_power), 32'(venc_pkg::DAC_RESET), "dac pins");
    chk(32'({hsync_oe_n, field_vsync_oe_n}), 32'h3, "oe");
    bus(1'b0, venc_pkg::OFS_MODE, 32'h0, 4'hF, q);
    chk(q, 32'(venc_pkg::MODE_RESET), "mode");
    bus(1'b1, venc_pkg::OFS_DAC, 32'h5, 4'h0, q);
    bus(1'b0, venc_pkg::OFS_DAC, 32'h0, 4'hF, q);
    chk(q, 32'h7, "dac");
    wr(venc_pkg::OFS_DAC, 32'h5);
    chk(32'(dac_power), 32'h5, "dac new");
    wr(8'h20, 32'hFF);
    bus(1'b0, 8'h20, 32'h0, 4'hF, q);
    chk(q, 32'h0, "unmapped");
    addr_select_pin <= 1'b1;
    // Address register follows the pin one cycle late
    @(posedge clk);
    bus(1'b0, venc_pkg::OFS_STATUS, 32'h0, 4'hF, q);
    chk(32'(q[14:8]), 32'({venc_pkg::SERIAL_ADDR_BASE, 1'b1}), "addr");
    $display("test regs done");
  endtask
  task automatic t_pixel(input logic wide);
    logic [15:0] w, pw;
    logic b, s;
    s = 1'b0;
    wr(venc_pkg::OFS_MODE, {27'h0, wide, 4'h0});
    repeat (40) begin
      w = pixel_bus;
      b = blank_n;
      @(posedge clk);
      s = s | b;
      if (b) pw = wide ? w : {8'h00, w[7:0]};
      if (s) chk(32'(pixel_word), 32'(pw), "pixel");
      chk(32'(pixel_valid), 32'(b), "valid");
    end
    $display("test pixel done");
  endtask
  task automatic t_sync();
    logic [7:0] m [5] = '{8'h02, 8'h06, 8'h0A, 8'h0E, 8'h08};
    logic e;
    logic [31:0] q;
    int n;
    for (int i = 0; i < 5; i++) begin
      wr(venc_pkg::OFS_MODE, 32'(m[i]));
      e = !(m[i][1] && (m[i][3:2] == 2'h1 || m[i][3:2] == 2'h2));
      repeat (2) @(posedge clk);
      chk(32'({hsync_oe_n, field_vsync_oe_n}), e ? 32'h3 : 32'h0, "oe");
      if (!e) begin
        // Mode 1 pin carries the field bit, still zero since reset
        if (m[i][3:2] == 2'h1) begin
          bus(1'b0, venc_pkg::OFS_STATUS, 32'h0, 4'hF, q);
          chk(32'(field_vsync_out), 32'(q[5]), "field pin");
          chk(32'(q[5]), 32'h0, "field bit");
        end
        wait_hs(1'b1);
        wait_hs(1'b0);
        n = 0;
        while (hsync_out === 1'b0 && n < 200) begin
          @(posedge clk);
          n++;
        end
        chk(32'(n), 32'(venc_pkg::HSYNC_CLOCKS), "hsync width");
      end
    end
    $display("test sync done");
  endtask
  task automatic pin_read(output logic [31:0] q);
    subcarrier_ctrl_pin <= 1'b1;
    repeat (12) @(posedge clk);
    bus(1'b0, venc_pkg::OFS_STATUS, 32'h0, 4'hF, q);
    subcarrier_ctrl_pin <= 1'b0;
    @(posedge clk);
  endtask
  task automatic t_subc();
    logic [31:0] v0, v, q;
    wr(venc_pkg::OFS_MODE2, 32'h0);
    bus(1'b0, venc_pkg::OFS_STATUS, 32'h0, 4'hF, v0);
    run <= 1'b1;
    // One or two vsync falls, never a multiple of four
    repeat (300) @(posedge clk);
    run <= 1'b0;
    repeat (4) @(posedge clk);
    bus(1'b0, venc_pkg::OFS_STATUS, 32'h0, 4'hF, v);
    chk(32'(v[1:0] != v0[1:0]), 32'h1, "field count");
    pin_read(q);
    chk(32'(q[1:0]), 32'(v[1:0]), "pin unused");
    wr(venc_pkg::OFS_MODE2, 32'h2);
    pin_read(q);
    chk(32'(q[1:0]), 32'h0, "sc reset");
    wr(venc_pkg::OFS_MODE2, 32'h4);
    pin_read(q);
    chk(32'({q[23:16], q[4]}), 32'h1FF, "rtc");
    $display("test subcarrier done");
  endtask
  task automatic t_ttx();
    int p, q;
    p = 0;
    q = 0;
    wr(venc_pkg::OFS_MODE2, 32'h0);
    repeat (300) begin
      @(posedge clk);
      p += int'(teletext_request_out === 1'b1);
      q += int'(teletext_bit === 1'b1);
    end
    chk(32'(p), 32'h0, "ttx req");
    chk(32'(q), 32'(300), "ttx bit");
    wr(venc_pkg::OFS_MODE2, 32'h8);
    run <= 1'b1;
    repeat (600) begin
      @(posedge clk);
      p += int'(teletext_request_out === 1'b1);
    end
    run <= 1'b0;
    chk(32'(p != 0), 32'h1, "ttx req on");
    chk(32'(teletext_bit), 32'h0, "ttx data");
    $display("test teletext done");
  endtask
  initial begin
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_regs();
    t_pixel(1'b0);
    t_pixel(1'b1);
    t_sync();
    t_subc();
    t_ttx();
    conclude();
  end
endmodule

// [sim/video_source.sv]
// Video source model driving pixel and sync pins
`timescale 1ns/1ps
module video_source (
  // Clock and control
  input  wire logic   clk,
  input  wire logic   run,
  // Pins toward the encoder
  output logic [15:0] pixel_bus,
  output logic        blank_n,
  output logic        hsync_in,
  output logic        field_vsync_in
);
  logic [7:0] cnt = 8'h00;
  initial pixel_bus = 16'h0000;
  initial blank_n = 1'b0;
  initial hsync_in = 1'b1;
  initial field_vsync_in = 1'b1;
  // All pins change just after the rising edge
  always @(posedge clk) begin
    cnt <= cnt + 8'h01;
    pixel_bus <= {~cnt, cnt ^ 8'h5A};
    blank_n <= cnt[2:0] != 3'h7;
    hsync_in <= !run || cnt[5:0] > 6'h03;
    field_vsync_in <= !run || cnt > 8'h07;
  end
endmodule
